// file: rtl/asrb_top.sv
// asrb_top: register bank of the serial audio port
// assumes an 8-bit host register port, and a serial engine that moves samples
// between the buffers and the shifter, giving one-cycle event pulses.
`timescale 1ns/1ps
module asrb_top
  import asrb_pkg::*;
#(
  parameter int RX_W = 32
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    wake_deep_i,
  input  wire logic [15:0]             reg_addr_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  input  wire logic [7:0]              reg_wdata_i,
  output logic [7:0]                   reg_rdata_o,
  input  wire logic                    ws_edge_i,
  input  wire logic                    sof_trig_i,
  input  wire logic                    pin_transition_trigger_i,
  input  wire logic                    timer_compare_trigger_i,
  input  wire logic                    tx_take_i,
  input  wire logic                    rx_put_i,
  input  wire logic [RX_W-1:0]         rx_sample_i,
  input  wire logic [5:0]              rx_len_m1_i,
  input  wire logic                    rx_right_i,
  output logic [asrb_pkg::DATA_W-1:0]  tx_sample_o,
  output logic                         tx_valid_o,
  output logic                         tx_underflow_o,
  output logic                         transmit_channel_next_o,
  output logic [4:0]                   sample_length_o,
  output logic                         pin_location_select_o,
  output logic                         pin_priority_o,
  output logic [8:0]                   divider_divisor_o,
  output logic [14:0]                  divider_dividend_o
);
  // ==================================================================
  // register state
  logic [4:0]  words_q, words_d;
  asrb_trig_t  trig_q, trig_d;
  logic        loc_q, loc_d;
  logic [7:0]  datl_q, datl_d, dath_q, dath_d;
  logic [7:0]  rxl_q, rxl_d, rxh_q, rxh_d;
  logic        low_wr_q, low_wr_d;
  logic        txfull_q, txfull_d, rxfull_q, rxfull_d;
  logic        unf_q, unf_d, ovf_q, ovf_d;
  logic        transmit_channel_next_q, transmit_channel_next_d, receive_channel_held_q, receive_channel_held_d;
  logic        txp_q, txp_d, rxp_q, rxp_d;
  logic [7:0]  clkf0_q, clkf0_d, clkf1_q, clkf1_d, clkf2_q, clkf2_d;
  logic [7:0]  rdata_q, rdata_d;
  logic [DATA_W-1:0] txs_q, txs_d;
  logic        txv_q, txv_d, txu_q, txu_d;
  logic [CAPTURED_WORD_COUNT_W-1:0] captured_word_count;
  logic        capture, trig_hit;
  logic [DATA_W-1:0] rx_top;

  wire wr_cfg  = reg_wr_i && reg_addr_i == ADDR_CFG1;
  wire wr_datl = reg_wr_i && reg_addr_i == ADDR_DATL;
  wire wr_dath = reg_wr_i && reg_addr_i == ADDR_DATH;
  wire wr_captured_word_count = reg_wr_i && reg_addr_i == ADDR_CAPTURED_WORD_COUNT;
  wire wr_stat = reg_wr_i && reg_addr_i == ADDR_STAT;
  wire rd_dath = reg_rd_i && reg_addr_i == ADDR_DATH;

  // ==================================================================
  // word counter triggers
  always_comb begin
    unique case (trig_q)
      ASRB_TRIG_SOFT:  trig_hit = 1'b0;
      ASRB_TRIG_SOF:   trig_hit = sof_trig_i;
      ASRB_TRIG_PIN:   trig_hit = pin_transition_trigger_i;
      ASRB_TRIG_TIMER: trig_hit = timer_compare_trigger_i;
    endcase
    capture = wr_captured_word_count || trig_hit;
  end

  asrb_word_counter #(.W(CAPTURED_WORD_COUNT_W)) asrb_word_counter_i (
    .sys_clk_i  (sys_clk_i),
    .sys_rst_i  (sys_rst_i),
    .ws_edge_i  (ws_edge_i),
    .capture_i  (capture),
    .captured_o (captured_word_count)
  );

  // left-justify the received word: top sixteen bits only
  always_comb begin
    rx_top = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (int'(rx_len_m1_i) >= i && int'(rx_len_m1_i) - i < RX_W)
        rx_top[DATA_W-1-i] = rx_sample_i[int'(rx_len_m1_i) - i];
    end
  end

  // ==================================================================
  // next-state logic
  always_comb begin
    words_d  = words_q;
    trig_d   = trig_q;
    loc_d    = loc_q;
    datl_d   = datl_q;
    dath_d   = dath_q;
    rxl_d    = rxl_q;
    rxh_d    = rxh_q;
    low_wr_d = low_wr_q;
    txfull_d = txfull_q;
    rxfull_d = rxfull_q;
    unf_d    = unf_q;
    ovf_d    = ovf_q;
    transmit_channel_next_d   = transmit_channel_next_q;
    receive_channel_held_d   = receive_channel_held_q;
    txp_d    = txp_q;
    rxp_d    = rxp_q;
    clkf0_d  = clkf0_q;
    clkf1_d  = clkf1_q;
    clkf2_d  = clkf2_q;
    txs_d    = txs_q;
    txv_d    = 1'b0;
    txu_d    = 1'b0;

    if (wr_cfg) begin
      words_d = reg_wdata_i[CFG_WORDS_HI:CFG_WORDS_LO];
      trig_d  = asrb_trig_t'(reg_wdata_i[CFG_TRIG_HI:CFG_TRIG_LO]);
      loc_d   = reg_wdata_i[CFG_LOC_BIT];
    end
    if (reg_wr_i && reg_addr_i == ADDR_CLKF0) clkf0_d = reg_wdata_i;
    if (reg_wr_i && reg_addr_i == ADDR_CLKF1) clkf1_d = reg_wdata_i;
    if (reg_wr_i && reg_addr_i == ADDR_CLKF2) clkf2_d = reg_wdata_i;

    // software clears come first so a same-cycle hardware set wins
    if (wr_stat) begin
      if (!reg_wdata_i[ST_UNF]) unf_d = 1'b0;
      if (!reg_wdata_i[ST_OVF]) ovf_d = 1'b0;
      if (reg_wdata_i[ST_TXP])  txp_d = 1'b1;
      if (reg_wdata_i[ST_RXP])  rxp_d = 1'b1;
    end

    if (wr_datl) begin
      datl_d   = reg_wdata_i;
      low_wr_d = 1'b1;
    end
    if (wr_dath) begin
      dath_d   = reg_wdata_i;
      if (!low_wr_q) datl_d = '0;
      low_wr_d = 1'b0;
      txfull_d = 1'b1;
      txp_d    = 1'b0;
    end
    if (rd_dath) begin
      rxfull_d = 1'b0;
      rxp_d    = 1'b0;
    end

    if (tx_take_i) begin
      transmit_channel_next_d = ~transmit_channel_next_q;
      if (txfull_q) begin
        txs_d    = {dath_q, datl_q};
        txv_d    = 1'b1;
        txfull_d = wr_dath;
        txp_d    = 1'b1;
      end else begin
        txs_d = '0;
        txu_d = 1'b1;
        unf_d = 1'b1;
      end
    end
    if (rx_put_i) begin
      if (rxfull_q && !rd_dath) ovf_d = 1'b1;
      {rxh_d, rxl_d} = rx_top;
      receive_channel_held_d   = rx_right_i;
      rxfull_d = 1'b1;
      rxp_d    = 1'b1;
    end

    if (wake_deep_i) begin
      datl_d = '0;
      dath_d = '0;
      rxl_d  = '0;
      rxh_d  = '0;
    end
  end

  // ==================================================================
  // read path, registered
  always_comb begin
    unique case (reg_addr_i)
      ADDR_CFG1:  rdata_d = {words_q, trig_q, loc_q};
      ADDR_DATL:  rdata_d = rxl_q;
      ADDR_DATH:  rdata_d = rxh_q;
      ADDR_CAPTURED_WORD_COUNT:  rdata_d = captured_word_count[7:0];
      ADDR_STAT:  rdata_d = {unf_q, ovf_q, transmit_channel_next_q, receive_channel_held_q, txp_q, rxp_q,
                             captured_word_count[9:8]};
      ADDR_CLKF0: rdata_d = clkf0_q;
      ADDR_CLKF1: rdata_d = clkf1_q;
      ADDR_CLKF2: rdata_d = clkf2_q;
      default:    rdata_d = 8'h00;
    endcase
    if (!reg_rd_i) rdata_d = rdata_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      words_q  <= WORDS_RST;
      trig_q   <= ASRB_TRIG_SOFT;
      loc_q    <= 1'b0;
      datl_q   <= 8'h00;
      dath_q   <= 8'h00;
      rxl_q    <= 8'h00;
      rxh_q    <= 8'h00;
      low_wr_q <= 1'b1;
      txfull_q <= 1'b0;
      rxfull_q <= 1'b0;
      unf_q    <= 1'b0;
      ovf_q    <= 1'b0;
      transmit_channel_next_q   <= 1'b0;
      receive_channel_held_q   <= 1'b0;
      txp_q    <= 1'b0;
      rxp_q    <= 1'b0;
      clkf0_q  <= CLKF0_RST;
      clkf1_q  <= CLKF1_RST;
      clkf2_q  <= {DENHI_RST, NUMHI_RST};
      rdata_q  <= 8'h00;
      txs_q    <= '0;
      txv_q    <= 1'b0;
      txu_q    <= 1'b0;
    end else begin
      words_q  <= words_d;
      trig_q   <= trig_d;
      loc_q    <= loc_d;
      datl_q   <= datl_d;
      dath_q   <= dath_d;
      rxl_q    <= rxl_d;
      rxh_q    <= rxh_d;
      low_wr_q <= low_wr_d;
      txfull_q <= txfull_d;
      rxfull_q <= rxfull_d;
      unf_q    <= unf_d;
      ovf_q    <= ovf_d;
      transmit_channel_next_q   <= transmit_channel_next_d;
      receive_channel_held_q   <= receive_channel_held_d;
      txp_q    <= txp_d;
      rxp_q    <= rxp_d;
      clkf0_q  <= clkf0_d;
      clkf1_q  <= clkf1_d;
      clkf2_q  <= clkf2_d;
      rdata_q  <= rdata_d;
      txs_q    <= txs_d;
      txv_q    <= txv_d;
      txu_q    <= txu_d;
    end
  end

  // ==================================================================
  // outputs, all from flops except the constant pin_priority_o
  assign reg_rdata_o             = rdata_q;
  assign tx_sample_o             = txs_q;
  assign tx_valid_o              = txv_q;
  assign tx_underflow_o          = txu_q;
  assign transmit_channel_next_o = transmit_channel_next_q;
  assign sample_length_o         = words_q;
  assign pin_location_select_o   = loc_q;
  // the port always claims its pins; the pin mux lets only debug override it
  assign pin_priority_o          = 1'b1;
  // no ratio clamp here: software keeps dividend over divisor at 3.35 or more
  assign divider_divisor_o       = {clkf2_q[7], clkf0_q};
  assign divider_dividend_o      = {clkf2_q[6:0], clkf1_q};

  // ==================================================================
  // checks
  AST_DOUBLE_HIGH: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_dath && !low_wr_q && !wake_deep_i) |=> datl_q == 8'h00)
    else $error("low byte not cleared on double high write");
  AST_WAKE_CLEAR: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wake_deep_i |=> (datl_q == 8'h00 && dath_q == 8'h00))
    else $error("data bytes not cleared on wake");
  AST_RD_HIGH: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (rd_dath && !rx_put_i && !(wr_stat && reg_wdata_i[ST_RXP])) |=> !rxp_q && !rxfull_q)
    else $error("high read left receive pending");
  AST_WR_HIGH: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_dath && !tx_take_i) |=> txfull_q && !txp_q)
    else $error("high write did not fill transmit buffer");
  AST_UNF_STICKY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (unf_q && !(wr_stat && !reg_wdata_i[ST_UNF])) |=> unf_q)
    else $error("underflow flag dropped by itself");
  AST_OVF_STICKY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (ovf_q && !(wr_stat && !reg_wdata_i[ST_OVF])) |=> ovf_q)
    else $error("overflow flag dropped by itself");
  AST_UNDERFLOW: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (tx_take_i && !txfull_q) |=> unf_q && tx_underflow_o)
    else $error("underflow not flagged");
  AST_OVERFLOW: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (rx_put_i && rxfull_q && !rd_dath) |=> ovf_q)
    else $error("overflow not flagged");
  AST_RX_SET: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    rx_put_i |=> rxp_q && rxfull_q && receive_channel_held_q == $past(rx_right_i))
    else $error("receive arrival not flagged");
  AST_STATUS_CNT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_addr_i == ADDR_STAT) |=> reg_rdata_o[1:0] == $past(captured_word_count[9:8]))
    else $error("status count bits wrong");

  COV_TX: cover property (@(posedge sys_clk_i) wr_dath ##[1:20] tx_valid_o);
  COV_RX: cover property (@(posedge sys_clk_i) rx_put_i ##[1:20] rd_dath);
  COV_UNF: cover property (@(posedge sys_clk_i) tx_underflow_o);
  COV_TRIG: cover property (@(posedge sys_clk_i) trig_hit);
endmodule

// file: rtl/asrb_pkg.sv
// asrb_pkg: register map, field positions and reset values of the audio port register bank
// assumes an 8-bit memory-mapped register access from the host processor
package asrb_pkg;
  localparam logic [15:0] ADDR_CFG1   = 16'hdf41;
  localparam logic [15:0] ADDR_DATL   = 16'hdf42;
  localparam logic [15:0] ADDR_DATH   = 16'hdf43;
  localparam logic [15:0] ADDR_CAPTURED_WORD_COUNT   = 16'hdf44;
  localparam logic [15:0] ADDR_STAT   = 16'hdf45;
  localparam logic [15:0] ADDR_CLKF0  = 16'hdf46;
  localparam logic [15:0] ADDR_CLKF1  = 16'hdf47;
  localparam logic [15:0] ADDR_CLKF2  = 16'hdf48;

  localparam int CFG_WORDS_HI = 7;
  localparam int CFG_WORDS_LO = 3;
  localparam int CFG_TRIG_HI  = 2;
  localparam int CFG_TRIG_LO  = 1;
  localparam int CFG_LOC_BIT  = 0;
  localparam logic [4:0] WORDS_RST = 5'h0f;

  localparam int ST_UNF  = 7;
  localparam int ST_OVF  = 6;
  localparam int ST_TRANSMIT_CHANNEL_NEXT = 5;
  localparam int ST_RECEIVE_CHANNEL_HELD = 4;
  localparam int ST_TXP  = 3;
  localparam int ST_RXP  = 2;

  localparam logic [7:0] CLKF0_RST = 8'h93;
  localparam logic [7:0] CLKF1_RST = 8'he2;
  localparam logic [6:0] NUMHI_RST = 7'h04;
  localparam logic       DENHI_RST = 1'b0;

  localparam int CAPTURED_WORD_COUNT_W = 10;
  localparam int DATA_W = 16;

  typedef enum logic [1:0] {
    ASRB_TRIG_SOFT,
    ASRB_TRIG_SOF,
    ASRB_TRIG_PIN,
    ASRB_TRIG_TIMER
  } asrb_trig_t;
endpackage

// file: rtl/asrb_word_counter.sv
// asrb_word_counter: saturating word-select transition counter with capture and clear
// assumes ws_edge_i is a one-cycle pulse per word-select transition
`timescale 1ns/1ps
module asrb_word_counter #(
  parameter int W = 10
) (
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         ws_edge_i,
  input  wire logic         capture_i,
  output logic [W-1:0]      captured_o
);
  logic [W-1:0] cnt_q, cnt_d, cap_q, cap_d;

  always_comb begin
    cap_d = cap_q;
    cnt_d = cnt_q;
    if (capture_i) begin
      cap_d = cnt_q;
      cnt_d = '0;
    end else if (ws_edge_i && cnt_q != {W{1'b1}}) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      cap_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      cap_q <= cap_d;
    end
  end

  assign captured_o = cap_q;

  AST_SATURATE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (cnt_q == {W{1'b1}} && !capture_i) |=> cnt_q == {W{1'b1}})
    else $error("word counter wrapped");
  AST_CAPTURE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    capture_i |=> (cap_q == $past(cnt_q)) && cnt_q == '0)
    else $error("capture did not copy and clear");
endmodule

// file: verification/asrb_far_model.sv
// asrb_far_model: behavioural serial engine and codec on the far side of the bank
// assumes the bench calls its tasks; every pulse starts 1 ns after a rising edge
`timescale 1ns/1ps
module asrb_far_model #(
  parameter int RX_W = 32
) (
  input  wire logic                        sys_clk_i,
  input  wire logic [asrb_pkg::DATA_W-1:0] tx_sample_i,
  input  wire logic                        tx_valid_i,
  input  wire logic                        tx_underflow_i,
  output logic                             ws_edge_o,
  output logic                             tx_take_o,
  output logic                             rx_put_o,
  output logic [RX_W-1:0]                  rx_sample_o,
  output logic [5:0]                       rx_len_m1_o,
  output logic                             rx_right_o
);
  import asrb_pkg::*;

  initial begin
    ws_edge_o   = 1'b0;
    tx_take_o   = 1'b0;
    rx_put_o    = 1'b0;
    rx_sample_o = '0;
    rx_len_m1_o = 6'h0f;
    rx_right_o  = 1'b0;
  end

  // =====================================================
  // word select: one pulse per transition, a gap between
  task automatic ws_edges(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      #1;
      ws_edge_o = 1'b1;
      @(posedge sys_clk_i);
      #1;
      ws_edge_o = 1'b0;
    end
  endtask

  // =====================================================
  // shifter asks for a sample, even with the buffer empty
  task automatic take(output logic v, output logic u, output logic [DATA_W-1:0] s);
    @(posedge sys_clk_i);
    #1;
    tx_take_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    tx_take_o = 1'b0;
    v = tx_valid_i;
    u = tx_underflow_i;
    s = tx_sample_i;
  endtask

  // =====================================================
  // received sample lands whether or not software has read the last one
  task automatic put(input logic [RX_W-1:0] d, input logic [5:0] l, input logic r);
    @(posedge sys_clk_i);
    #1;
    rx_sample_o = d;
    rx_len_m1_o = l;
    rx_right_o  = r;
    rx_put_o    = 1'b1;
    @(posedge sys_clk_i);
    #1;
    rx_put_o    = 1'b0;
    // released lines show garbage, so a stale value can never pass
    rx_sample_o = ~d;
    rx_right_o  = ~r;
  endtask
endmodule

// file: verification/test_audio_serial_register_bank.sv
// test_audio_serial_register_bank: self-checking bench of the audio register bank
// assumes asrb_top and asrb_far_model; drives inputs 1 ns after each rising edge
`timescale 1ns/1ps
module test_audio_serial_register_bank;
  import asrb_pkg::*;
  logic                sys_clk_i;
  logic                sys_rst_i;
  logic                wake_deep_i;
  logic [15:0]         reg_addr_i;
  logic                reg_wr_i;
  logic                reg_rd_i;
  logic [7:0]          reg_wdata_i;
  logic [7:0]          reg_rdata_o;
  logic                ws_edge, tx_take, rx_put, rx_right;
  logic                trig_sof, trig_pin, trig_tim;
  logic [31:0]         rx_sample;
  logic [5:0]          rx_len_m1;
  logic [DATA_W-1:0]   tx_sample;
  logic                tx_valid, tx_und, tx_next, loc, prio;
  logic [4:0]          len;
  logic [8:0]          divisor;
  logic [14:0]         dividend;
  int                  miscompares = 0;
  int                  tests_run = 0;

  asrb_top #(.RX_W(32)) asrb_top_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .wake_deep_i(wake_deep_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .ws_edge_i(ws_edge), .sof_trig_i(trig_sof), .pin_transition_trigger_i(trig_pin),
    .timer_compare_trigger_i(trig_tim), .tx_take_i(tx_take), .rx_put_i(rx_put),
    .rx_sample_i(rx_sample), .rx_len_m1_i(rx_len_m1), .rx_right_i(rx_right),
    .tx_sample_o(tx_sample), .tx_valid_o(tx_valid), .tx_underflow_o(tx_und),
    .transmit_channel_next_o(tx_next), .sample_length_o(len),
    .pin_location_select_o(loc), .pin_priority_o(prio),
    .divider_divisor_o(divisor), .divider_dividend_o(dividend));

  asrb_far_model #(.RX_W(32)) asrb_far_model_i (.sys_clk_i(sys_clk_i),
    .tx_sample_i(tx_sample), .tx_valid_i(tx_valid), .tx_underflow_i(tx_und),
    .ws_edge_o(ws_edge), .tx_take_o(tx_take), .rx_put_o(rx_put),
    .rx_sample_o(rx_sample), .rx_len_m1_o(rx_len_m1), .rx_right_o(rx_right));

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // =====================================================
  // helpers
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reg_wr_i    = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    @(posedge sys_clk_i);
    #1;
    reg_rd_i   = 1'b0;
    d          = reg_rdata_o;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input string w);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, e}, w);
  endtask

  task automatic trig(input int k);
    @(posedge sys_clk_i);
    #1;
    trig_sof = (k == 1);
    trig_pin = (k == 2);
    trig_tim = (k == 3);
    @(posedge sys_clk_i);
    #1;
    {trig_sof, trig_pin, trig_tim} = 3'h0;
  endtask

  // =====================================================
  // scenarios
  task automatic t_reset;
    rchk(ADDR_CFG1, 8'h78, "cfg1 reset");
    rchk(ADDR_CLKF0, 8'h93, "clk0 reset");
    rchk(ADDR_CLKF1, 8'he2, "clk1 reset");
    rchk(ADDR_CLKF2, 8'h04, "clk2 reset");
    rchk(ADDR_DATL, 8'h00, "datl reset");
    rchk(ADDR_DATH, 8'h00, "dath reset");
    rchk(ADDR_CAPTURED_WORD_COUNT, 8'h00, "captured_word_count reset");
    rchk(ADDR_STAT, 8'h00, "stat reset");
    rchk(16'hdf40, 8'h00, "unmapped");
    chk({7'h0, divisor}, 16'h0093, "divisor reset");
    chk({1'b0, dividend}, 16'h04e2, "dividend reset");
  endtask

  task automatic t_config;
    wr(ADDR_CFG1, 8'ha5);
    chk({11'h0, len}, 16'h0014, "length out");
    chk({14'h0, prio, loc}, 16'h0003, "location");
    rchk(ADDR_CFG1, 8'ha5, "cfg1 back");
    wr(ADDR_CLKF0, 8'h10);
    wr(ADDR_CLKF1, 8'h7d);
    wr(ADDR_CLKF2, 8'h84);
    chk({7'h0, divisor}, 16'h0110, "divisor");
    chk({1'b0, dividend}, 16'h047d, "dividend");
    rchk(ADDR_CLKF2, 8'h84, "clk2 back");
  endtask

  task automatic t_tx;
    logic v, u;
    logic [15:0] s;
    wr(ADDR_DATL, 8'h34);
    wr(ADDR_DATH, 8'h12);
    asrb_far_model_i.take(v, u, s);
    chk({v, u, 14'h0}, 16'h8000, "tx flags");
    chk(s, 16'h1234, "tx sample");
    chk({15'h0, tx_next}, 16'h0001, "tx next");
    rchk(ADDR_STAT, 8'h28, "stat after take");
    wr(ADDR_DATL, 8'h78);
    wr(ADDR_DATH, 8'h9a);
    wr(ADDR_DATH, 8'hbc);
    rchk(ADDR_STAT, 8'h20, "tx pending cleared");
    wr(ADDR_STAT, 8'hc8);
    rchk(ADDR_STAT, 8'h28, "tx pending by write");
    asrb_far_model_i.take(v, u, s);
    chk(s, 16'hbc00, "low byte cleared");
    asrb_far_model_i.take(v, u, s);
    chk({u, 15'h0}, 16'h8000, "underflow pulse");
    chk(s, 16'h0000, "underflow data");
    rchk(ADDR_STAT, 8'ha8, "underflow flag");
    rchk(ADDR_STAT, 8'ha8, "underflow sticky");
    wr(ADDR_STAT, 8'h40);
    rchk(ADDR_STAT, 8'h28, "underflow cleared");
    wr(ADDR_STAT, 8'h44);
    rchk(ADDR_STAT, 8'h2c, "rx pending by write");
  endtask

  task automatic t_rx;
    logic [7:0] d;
    asrb_far_model_i.put(32'habcd1234, 6'd31, 1'b1);
    rchk(ADDR_STAT, 8'h3c, "rx arrived");
    rchk(ADDR_DATL, 8'hcd, "rx low top bits");
    rchk(ADDR_DATH, 8'hab, "rx high top bits");
    rchk(ADDR_STAT, 8'h38, "rx read clears");
    asrb_far_model_i.put(32'h0000005a, 6'd7, 1'b0);
    rchk(ADDR_DATL, 8'h00, "short low");
    rchk(ADDR_DATH, 8'h5a, "short high");
    rchk(ADDR_STAT, 8'h28, "left held");
    asrb_far_model_i.put(32'h11112222, 6'd31, 1'b0);
    asrb_far_model_i.put(32'h33334444, 6'd31, 1'b1);
    rd(ADDR_STAT, d);
    chk({8'h0, d & 8'hec}, 16'h006c, "overflow");
    rd(ADDR_DATH, d);
    wr(ADDR_STAT, 8'h80);
    rd(ADDR_STAT, d);
    chk({8'h0, d & 8'hec}, 16'h0028, "overflow cleared");
  endtask

  task automatic t_wake;
    asrb_far_model_i.put(32'h12345678, 6'd31, 1'b0);
    @(posedge sys_clk_i);
    #1;
    wake_deep_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    wake_deep_i = 1'b0;
    rchk(ADDR_DATL, 8'h00, "wake low");
    rchk(ADDR_DATH, 8'h00, "wake high");
  endtask

  task automatic t_count;
    logic [7:0] d;
    wr(ADDR_CFG1, 8'h78);
    asrb_far_model_i.ws_edges(5);
    for (int k = 1; k <= 3; k++) trig(k);
    wr(ADDR_CAPTURED_WORD_COUNT, 8'hff);
    rchk(ADDR_CAPTURED_WORD_COUNT, 8'h05, "soft capture");
    wr(ADDR_CAPTURED_WORD_COUNT, 8'h00);
    rchk(ADDR_CAPTURED_WORD_COUNT, 8'h00, "counter cleared");
    for (int k = 1; k <= 3; k++) begin
      wr(ADDR_CFG1, {5'h0f, k[1:0], 1'b0});
      asrb_far_model_i.ws_edges(k + 2);
      trig(k % 3 + 1);
      trig((k + 1) % 3 + 1);
      trig(k);
      rchk(ADDR_CAPTURED_WORD_COUNT, 8'(k + 2), "trigger capture");
    end
    wr(ADDR_CFG1, 8'h78);
    asrb_far_model_i.ws_edges(1030);
    wr(ADDR_CAPTURED_WORD_COUNT, 8'h00);
    rchk(ADDR_CAPTURED_WORD_COUNT, 8'hff, "saturated low");
    rd(ADDR_STAT, d);
    chk({14'h0, d[1:0]}, 16'h0003, "saturated high");
  endtask

  // =====================================================
  // main sequence and hang guard
  initial begin
    sys_rst_i   = 1'b1;
    wake_deep_i = 1'b0;
    reg_addr_i  = 16'h0000;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    reg_wdata_i = 8'h00;
    {trig_sof, trig_pin, trig_tim} = 3'h0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset;
    t_config;
    t_tx;
    t_rx;
    t_wake;
    t_count;
    finish_test;
  end

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    miscompares++;
    finish_test;
  end
endmodule
